// >>> verilog/dso_status_outputs.sv
`timescale 1ns/1ps
// ****************************************************************
// Drive status outputs.
// ****************************************************************
module dso_status_outputs
    import dso_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             error_event,
    input  wire logic             warning_active,
    input  wire logic             fault_clear_command,
    input  wire logic             motor_power_command,
    input  wire logic [SPD_W-1:0] motor_speed,
    input  wire logic [SPD_W-1:0] reference_speed,
    input  wire dso_mode_t        control_mode,
    input  wire logic [13:0]      rotation_detect_level,
    input  wire logic [6:0]       speed_match_width,
    input  wire dso_assign_t      pin_assign,
    input  wire dso_ready_t       ready_in,
    output logic                  fault_output,
    output logic                  caution_output,
    output logic                  rotation_detect_output,
    output logic                  prepared_output,
    output logic                  speed_match_output,
    output logic                  servo_on_accepted
);

    // ************************************************************
    // Fault latch.
    // ************************************************************

    // Latched fault; set has priority over the clear command.
    logic fault_latched;
    wire  next_fault = error_event |
                       (fault_latched & ~fault_clear_command);

    // The latch holds until the host clears it; a new error wins.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_latched <= 1'b0;
        end else begin
            fault_latched <= next_fault;
        end
    end

    // ************************************************************
    // Speed comparisons.
    // ************************************************************

    // Magnitude of the measured speed, direction does not matter.
    wire logic [SPD_W-1:0] speed_abs = motor_speed[SPD_W-1] ?
                                       (~motor_speed + 1'b1) : motor_speed;

    // Out of range levels are clamped into the settable range.
    wire logic [13:0] rot_level =
        (rotation_detect_level < ROT_LEVEL_MIN) ? ROT_LEVEL_MIN :
        (rotation_detect_level > ROT_LEVEL_MAX) ? ROT_LEVEL_MAX :
        rotation_detect_level;
    wire logic [6:0] match_width =
        (speed_match_width > MATCH_WIDTH_MAX) ? MATCH_WIDTH_MAX :
        speed_match_width;

    // Rotation detect compares magnitude with the level.
    wire logic rotating = speed_abs >= {2'h0, rot_level};

    // Speed error, one bit wider so the subtraction cannot wrap.
    wire logic signed [SPD_W:0] speed_err =
        $signed({reference_speed[SPD_W-1], reference_speed}) -
        $signed({motor_speed[SPD_W-1], motor_speed});
    wire logic [SPD_W:0] err_abs = speed_err[SPD_W] ?
                                   (~speed_err + 1'b1) : speed_err;
    wire logic in_window = err_abs <= {10'h000, match_width};
    wire logic matched = in_window &
                         (control_mode == DSO_MODE_SPEED);

    // ************************************************************
    // Prepared condition.
    // ************************************************************

    wire logic encoder_ok = ~ready_in.absolute_encoder |
                            ready_in.encoder_power_command;
    wire logic prepared = ready_in.main_power &
                          ~ready_in.hardwired_baseblock &
                          ~next_fault & encoder_ok;

    // ************************************************************
    // Output registers, refreshed every cycle with no filtering.
    // ************************************************************

    // Out of reset, fault output is high (closed) while no fault is latched; reset drives it low.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_output           <= 1'b0;
            caution_output         <= 1'b0;
            rotation_detect_output <= 1'b0;
            prepared_output        <= 1'b0;
            speed_match_output     <= 1'b0;
            servo_on_accepted      <= 1'b0;
        end else begin
            fault_output <= ~next_fault;
            caution_output <= pin_assign.caution &
                              warning_active;
            rotation_detect_output <= pin_assign.rotation &
                                      rotating;
            prepared_output <= pin_assign.prepared &
                               prepared;
            speed_match_output <= pin_assign.speed_match &
                                  matched;
            servo_on_accepted <= prepared &
                                 motor_power_command;
        end
    end

endmodule

// >>> verilog/dso_pkg.sv
// ****************************************************************
// Shared constants and types of the drive status outputs.
// ****************************************************************
package dso_pkg;

    // Width of speed values in revolutions per minute, signed.
    localparam int SPD_W = 16;

    // Rotation detect level limits and reset default.
    localparam logic [13:0] ROT_LEVEL_MIN = 14'h0001;
    localparam logic [13:0] ROT_LEVEL_MAX = 14'h2710;
    localparam logic [13:0] ROT_LEVEL_DEF = 14'h0014;

    // Speed match width limits and reset default.
    localparam logic [6:0] MATCH_WIDTH_MAX = 7'h64;
    localparam logic [6:0] MATCH_WIDTH_DEF = 7'h0a;

    // Control mode encoding.
    typedef enum logic [1:0] {
        DSO_MODE_POSITION,
        DSO_MODE_SPEED,
        DSO_MODE_TORQUE
    } dso_mode_t;

    // Pin assignment enables of the optional outputs.
    typedef struct packed {
        logic caution;
        logic rotation;
        logic prepared;
        logic speed_match;
    } dso_assign_t;

    // Conditions feeding the prepared output.
    typedef struct packed {
        logic main_power;
        logic hardwired_baseblock;
        logic absolute_encoder;
        logic encoder_power_command;
    } dso_ready_t;

endpackage

// >>> test/dso_status_outputs_sva.sv
`timescale 1ns/1ps
module dso_status_outputs_sva import dso_pkg::*; (
    input wire logic clk, resetn, error_event, warning_active,
    input wire logic fault_clear_command, motor_power_command,
    input wire dso_mode_t control_mode,
    input wire dso_assign_t pin_assign,
    input wire dso_ready_t ready_in,
    input wire logic fault_output, caution_output, speed_match_output,
    input wire logic servo_on_accepted
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    fault_open_a: assert property (error_event |=> !fault_output)
        else $error("fault closed");
    fault_hold_a: assert property (!fault_output && $past(resetn)
        && !fault_clear_command |=> !fault_output) else $error("fault lost");
    fault_clear_a: assert property (fault_clear_command
        && !error_event |=> fault_output) else $error("fault kept");
    caution_a: assert property (1 |=> caution_output
        == $past(warning_active & pin_assign.caution)) else $error("caution");
    power_gate_a: assert property (!ready_in.main_power || error_event
        |=> !servo_on_accepted) else $error("power");
    block_gate_a: assert property (ready_in.hardwired_baseblock
        |=> !servo_on_accepted) else $error("block");
    encoder_gate_a: assert property (ready_in.absolute_encoder
        && !ready_in.encoder_power_command |=> !servo_on_accepted)
        else $error("encoder");
    accept_a: assert property (servo_on_accepted |-> fault_output
        && $past(motor_power_command)) else $error("accept");
    match_mode_a: assert property (control_mode != DSO_MODE_SPEED
        |=> !speed_match_output) else $error("match");
endmodule
bind dso_status_outputs dso_status_outputs_sva u_sva (.*);

// >>> test/dso_host_model.sv
`timescale 1ns/1ps
module dso_host_model (input wire logic clk, resetn, fault_output,
    output logic fault_clear_command, encoder_power_command);
    logic [3:0] dwell; // Time spent reading absolute position data.
    always_ff @(posedge clk or negedge resetn)
        if (!resetn) {dwell, fault_clear_command, encoder_power_command} <= '0;
        else begin
            fault_clear_command <= !fault_output && !fault_clear_command;
            dwell <= dwell + {3'h0, dwell != 4'hf};
            encoder_power_command <= dwell == 4'hf;
        end
endmodule

// >>> test/dso_status_outputs_bench.sv
`timescale 1ns/1ps
module dso_status_outputs_bench;
    import dso_pkg::*;
    logic clk = 1'h0, resetn = 1'h0, flt = 1'h0, nf, rdy;
    logic error_event, warning_active, motor_power_command;
    logic fault_clear_command, encoder_power_command, fault_output;
    logic caution_output, rotation_detect_output, prepared_output;
    logic speed_match_output, servo_on_accepted;
    logic [15:0] motor_speed, reference_speed;
    logic [13:0] rotation_detect_level;
    logic [6:0] speed_match_width;
    logic [2:0] rb;
    logic [31:0] r = 32'h4310;
    dso_mode_t control_mode = DSO_MODE_POSITION;
    dso_assign_t pin_assign;
    wire dso_ready_t ready_in = {rb, encoder_power_command};
    logic [5:0] notes[$];
    int n_errors = 0, cmp_count = 0, s, d, lv, wd;
    dso_status_outputs u_dso_status_outputs (.*);
    dso_host_model u_dso_host_model (.*);
    function automatic logic [31:0] step(logic [31:0] x);
        return x[31] ? {x[30:0], 1'h0} ^ 32'h04c11db7 : {x[30:0], 1'h0};
    endfunction
    task automatic check_outs(logic [5:0] e, logic [5:0] g);
        cmp_count++;
        if (g !== e) n_errors++;
        if (g !== e) $display("mismatch outputs expected %b seen %b", e, g);
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always #5 clk = ~clk;
    initial begin
        {error_event, warning_active, motor_power_command, rb} = '0;
        {pin_assign, motor_speed, reference_speed} = '0;
        {rotation_detect_level, speed_match_width} = '0;
        repeat (20) @(posedge clk);
        resetn <= 1'h1;
        repeat (3000) @(negedge clk);
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run();
    end
    // Each sampled edge leaves one note of all six expected outputs.
    always @(posedge clk) begin
        if (resetn) begin
            s = $signed(motor_speed);
            d = $signed(reference_speed) - s;
            lv = rotation_detect_level == 0 ? 1 : rotation_detect_level;
            lv = lv > 10000 ? 10000 : lv;
            wd = speed_match_width > 100 ? 100 : speed_match_width;
            nf = error_event | (flt & ~fault_clear_command);
            rdy = rb[2] & ~rb[1] & ~nf & (~rb[0] | encoder_power_command);
            flt = nf;
            notes.push_back({~nf, warning_active & pin_assign.caution,
                pin_assign.rotation & (s >= lv || -s >= lv),
                pin_assign.prepared & rdy,
                pin_assign.speed_match & control_mode == DSO_MODE_SPEED
                & d <= wd & -d <= wd, rdy & motor_power_command});
        end
        r <= step(r);
        error_event <= r[3:0] == 4'h0;
        {warning_active, motor_power_command, pin_assign, rb} <= r[12:4];
        control_mode <= dso_mode_t'(r[14:13] == 2'h3 ? 2'h1 : r[14:13]);
        reference_speed <= {{4{r[31]}}, r[31:20]};
        motor_speed <= {{4{r[31]}}, r[31:20]} + {{10{r[19]}}, r[19:14]};
        rotation_detect_level <= {r[15], 2'h0, r[30:20]};
        speed_match_width <= r[29:23];
    end
    always @(negedge clk) if (notes.size() > 0) check_outs(notes.pop_front(),
        {fault_output, caution_output, rotation_detect_output,
        prepared_output, speed_match_output, servo_on_accepted});
endmodule
